// ### sfv_cfg.svh
`ifndef SFV_CFG_SVH
`define SFV_CFG_SVH
// Volatile register fields
`define SFV_VCR_RST      8'hFB
`define SFV_DUMMY_HI     7
`define SFV_DUMMY_LO     4
`define SFV_XIP_BIT      3
`define SFV_RSVD_BIT     2
`define SFV_WRAP_HI      1
`define SFV_WRAP_LO      0
`define SFV_WRAP_SEQ     2'h3
`define SFV_WRAP_16      2'h0
`define SFV_WRAP_32      2'h1
`define SFV_MASK_16      24'h00000F
`define SFV_MASK_32      24'h00001F
`define SFV_MASK_64      24'h00003F
// Dummy-cycle codes
`define SFV_DUMMY_ZERO   4'h0
`define SFV_DUMMY_ONES   4'hF
`define SFV_DUMMY_DEF    4'hA
// Nonvolatile register fields
`define SFV_NVCR_RST     16'hFFFF
`define SFV_NV_DUMMY_HI  15
`define SFV_NV_DUMMY_LO  12
`define SFV_NV_XIP_HI    11
`define SFV_NV_XIP_LO    9
`define SFV_NV_XIP_OFF   3'h7
`define SFV_NV_QUAD      3
`define SFV_NV_DUAL      2
`define SFV_NV_LOCK      0
// Feature options that force execute-in-place
`define SFV_FEAT_XIP_A   4'h2
`define SFV_FEAT_XIP_B   4'h4
// Strap capture waits for both sync stages to hold the pin
`define SFV_STRAP_WAIT   2'h2
`endif

// ### sfv_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sfv_host_model
(
    input  wire logic               clk_i,        // Clock
    input  wire logic               stall_i,      // Hold off every beat
    input  wire logic               out_valid_i,  // Beat offered
    input  wire sfv_pkg::sfv_beat_t beat_i,       // Beat
    output logic                    ready_o       // Beat taken when high
);
    logic [1:0]         ph_q = 2'h0;
    sfv_pkg::sfv_beat_t beats[$];

    // Receiver also stalls one cycle in four on its own
    always @(negedge clk_i) ph_q <= ph_q + 2'h1;
    assign ready_o = !stall_i && (ph_q != 2'h3);
    always @(posedge clk_i) if (out_valid_i && ready_o) beats.push_back(beat_i);
endmodule
`default_nettype wire

// ### sfv_pkg.sv
package sfv_pkg;
    typedef enum logic [2:0] {
        SFV_OP_NOP,
        SFV_OP_WR_VCR,
        SFV_OP_RD_VCR,
        SFV_OP_WR_NVCR,
        SFV_OP_RD_NVCR,
        SFV_OP_FAST_READ
    } sfv_op_t;

    typedef struct packed {
        sfv_op_t     op;
        logic [23:0] addr;
        logic [15:0] data;
    } sfv_cmd_t;

    typedef struct packed {
        logic        is_reg;
        logic [23:0] addr;
        logic [15:0] data;
    } sfv_beat_t;
endpackage

// ### sfv_volatile_config.sv
// Summary of operation
// - Insert configured dummy cycles before read data
// - Codes 0000 and 1111 both mean default
// - Bit 3 low enables execute-in-place
// - Feature options 2, 4 force execute-in-place
// - Wrap codes select 16, 32, 64 windows
// - Wrap increments only bits inside window
// - Wrap code 11 reads sequentially
// - Volatile writes apply at once, reads return
// - Nonvolatile bits pick quad/dual at power-on
// - Serve nonvolatile reads; writes only while nonvolatile bit 0 is 1
// - Power-up loads from nonvolatile, shipped all ones
`include "sfv_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module sfv_volatile_config
(
    input  wire logic              clk_i,          // 250 MHz clock
    input  wire logic              sys_rst_i,      // Async reset, high
    input  wire logic              pwr_cycle_i,    // Power-on reload pulse
    input  wire logic [3:0]        feature_opt_i,  // Factory feature strap pin
    input  wire logic              cmd_valid_i,    // Command offered
    output logic                   cmd_ready_o,    // Command accepted when high
    input  wire sfv_pkg::sfv_cmd_t cmd_i,          // Command word
    input  wire logic              read_stop_i,    // Ends a read burst
    output logic                   out_valid_o,    // Beat available
    input  wire logic              out_ready_i,    // Receiver takes beat
    output sfv_pkg::sfv_beat_t     out_o,          // Beat
    output logic [7:0]             vcr_o,          // Volatile register
    output logic [3:0]             dummy_cnt_o,    // Decoded dummy count
    output logic                   xip_active_o,   // Execute-in-place on
    output logic                   quad_mode_o,    // Quad protocol
    output logic                   dual_mode_o     // Dual protocol
);
    typedef enum logic [1:0] {SFV_IDLE, SFV_DUMMY, SFV_DATA, SFV_REG} sfv_st_t;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [3:0] dummy_cycles(input logic [3:0] code);
        if (code == `SFV_DUMMY_ZERO || code == `SFV_DUMMY_ONES)
            return `SFV_DUMMY_DEF;
        return code;
    endfunction

    function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [1:0] w);
        logic [23:0] m;
        logic [23:0] inc;
        m = `SFV_MASK_64;
        inc = a + 24'h000001;
        case (w)
            `SFV_WRAP_16: m = `SFV_MASK_16;
            `SFV_WRAP_32: m = `SFV_MASK_32;
            `SFV_WRAP_SEQ: m = 24'hFFFFFF;
            default: m = `SFV_MASK_64;
        endcase
        return (a & ~m) | (inc & m);
    endfunction

    // ****************************************
    // Registers and strap
    // ****************************************
    sfv_st_t            st_q, st_d;
    logic [7:0]         vcr_q;
    logic [15:0]        nvcr_q;
    logic [3:0]         cnt_q;
    logic [23:0]        addr_q;
    logic [15:0]        rdat_q;
    logic [3:0]         feat_s1_q, feat_s2_q, feat_q;
    logic               strap_done_q;
    logic [1:0]         strap_cnt_q;
    logic               cmd_fire, push, in_ready, pop;
    sfv_pkg::sfv_beat_t in_beat, tail_q;
    logic               tv_q;

    assign cmd_fire = cmd_valid_i & cmd_ready_o;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            feat_s1_q    <= 4'h0;
            feat_s2_q    <= 4'h0;
            feat_q       <= 4'h0;
            strap_done_q <= 1'b0;
            strap_cnt_q  <= 2'h0;
        end
        else
        begin
            feat_s1_q <= feature_opt_i;
            feat_s2_q <= feat_s1_q;
            // Sampling earlier would capture the reset value of the sync stages
            if (!strap_done_q)
            begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
                if (strap_cnt_q == `SFV_STRAP_WAIT)
                begin
                    feat_q       <= feat_s2_q;
                    strap_done_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            nvcr_q <= `SFV_NVCR_RST;
        else if (cmd_fire && cmd_i.op == sfv_pkg::SFV_OP_WR_NVCR && nvcr_q[`SFV_NV_LOCK])
            nvcr_q <= cmd_i.data;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            vcr_q <= `SFV_VCR_RST;
        else if (pwr_cycle_i)
        begin
            vcr_q <= `SFV_VCR_RST;
            vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO] <= nvcr_q[`SFV_NV_DUMMY_HI:`SFV_NV_DUMMY_LO];
            vcr_q[`SFV_XIP_BIT] <= (nvcr_q[`SFV_NV_XIP_HI:`SFV_NV_XIP_LO] == `SFV_NV_XIP_OFF);
        end
        else if (cmd_fire && cmd_i.op == sfv_pkg::SFV_OP_WR_VCR)
        begin
            vcr_q <= cmd_i.data[7:0];
            vcr_q[`SFV_RSVD_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            quad_mode_o <= 1'b0;
            dual_mode_o <= 1'b0;
        end
        else if (pwr_cycle_i)
        begin
            quad_mode_o <= !nvcr_q[`SFV_NV_QUAD];
            dual_mode_o <= nvcr_q[`SFV_NV_QUAD] && !nvcr_q[`SFV_NV_DUAL];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            vcr_o        <= `SFV_VCR_RST;
            dummy_cnt_o  <= `SFV_DUMMY_DEF;
            xip_active_o <= 1'b0;
        end
        else
        begin
            vcr_o        <= vcr_q;
            dummy_cnt_o  <= dummy_cycles(vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO]);
            xip_active_o <= !vcr_q[`SFV_XIP_BIT]
                            || feat_q == `SFV_FEAT_XIP_A || feat_q == `SFV_FEAT_XIP_B;
        end
    end

    // ****************************************
    // Read sequencer
    // ****************************************
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            SFV_IDLE:
                if (cmd_fire && cmd_i.op == sfv_pkg::SFV_OP_FAST_READ)
                    st_d = SFV_DUMMY;
                else if (cmd_fire && (cmd_i.op == sfv_pkg::SFV_OP_RD_VCR || cmd_i.op == sfv_pkg::SFV_OP_RD_NVCR))
                    st_d = SFV_REG;
            SFV_DUMMY:
                if (read_stop_i || pwr_cycle_i)
                    st_d = SFV_IDLE;
                else if (cnt_q == 4'h1)
                    st_d = SFV_DATA;
            SFV_DATA:
                if (read_stop_i || pwr_cycle_i)
                    st_d = SFV_IDLE;
            SFV_REG:
                if (in_ready || pwr_cycle_i)
                    st_d = SFV_IDLE;
            default: st_d = SFV_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_q        <= SFV_IDLE;
            cmd_ready_o <= 1'b0;
        end
        else
        begin
            st_q        <= st_d;
            cmd_ready_o <= (st_d == SFV_IDLE) && !pwr_cycle_i;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cnt_q  <= 4'h0;
            addr_q <= 24'h000000;
            rdat_q <= 16'h0000;
        end
        else if (cmd_fire)
        begin
            cnt_q  <= dummy_cycles(vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO]);
            addr_q <= cmd_i.addr;
            rdat_q <= (cmd_i.op == sfv_pkg::SFV_OP_RD_NVCR) ? nvcr_q : {8'h00, vcr_q};
        end
        else if (st_q == SFV_DUMMY)
            cnt_q <= cnt_q - 4'h1;
        else if (push && st_q == SFV_DATA)
            addr_q <= next_addr(addr_q, vcr_q[`SFV_WRAP_HI:`SFV_WRAP_LO]);
    end

    assign push = in_ready && (st_q == SFV_DATA || st_q == SFV_REG) && !pwr_cycle_i
                  && !(st_q == SFV_DATA && read_stop_i);
    assign in_beat = '{is_reg: (st_q == SFV_REG), addr: addr_q, data: rdat_q};

    // ****************************************
    // Two-entry output buffer
    // ****************************************
    assign in_ready = !tv_q;
    assign pop      = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            out_valid_o <= 1'b0;
            out_o       <= '0;
            tv_q        <= 1'b0;
            tail_q      <= '0;
        end
        else if (pop && tv_q)
        begin
            out_o <= tail_q;
            tv_q  <= 1'b0;
        end
        else if (pop)
        begin
            out_valid_o <= push;
            if (push)
                out_o <= in_beat;
        end
        else if (push && !out_valid_o)
        begin
            out_o       <= in_beat;
            out_valid_o <= 1'b1;
        end
        else if (push)
        begin
            tail_q <= in_beat;
            tv_q   <= 1'b1;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    logic [3:0]  dseen_q;
    logic [23:0] last_q;
    logic        lv_q;
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            dseen_q <= 4'h0;
            last_q  <= 24'h000000;
            lv_q    <= 1'b0;
        end
        else
        begin
            dseen_q <= (st_q == SFV_DUMMY) ? dseen_q + 4'h1 : 4'h0;
            lv_q    <= (st_q == SFV_DATA) && (lv_q || push);
            if (push)
                last_q <= addr_q;
        end
    end

    sequence s_dummy_end;
        (st_q == SFV_DUMMY) ##1 (st_q == SFV_DATA);
    endsequence
    property p_dummy_len;
        s_dummy_end |-> dseen_q == dummy_cycles($past(vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO], 2));
    endproperty
    a_dummy_len: assert property (p_dummy_len) else $error("dummy length wrong");
    property p_dummy_def;
        (vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO] == `SFV_DUMMY_ZERO
            || vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO] == `SFV_DUMMY_ONES) |=> dummy_cnt_o == `SFV_DUMMY_DEF;
    endproperty
    a_dummy_def: assert property (p_dummy_def) else $error("default dummy wrong");
    property p_dummy_bin;
        (vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO] != `SFV_DUMMY_ZERO
            && vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO] != `SFV_DUMMY_ONES)
            |=> dummy_cnt_o == $past(vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO]);
    endproperty
    a_dummy_bin: assert property (p_dummy_bin) else $error("binary dummy wrong");
    property p_xip;
        strap_done_q |=> xip_active_o == (!$past(vcr_q[`SFV_XIP_BIT]) || feat_q == `SFV_FEAT_XIP_A
                                          || feat_q == `SFV_FEAT_XIP_B);
    endproperty
    a_xip: assert property (p_xip) else $error("xip state wrong");
    property p_wrap;
        push && lv_q |-> addr_q == next_addr(last_q, vcr_q[`SFV_WRAP_HI:`SFV_WRAP_LO]);
    endproperty
    a_wrap: assert property (p_wrap) else $error("burst address wrong");
    property p_vcr_wr;
        cmd_fire && cmd_i.op == sfv_pkg::SFV_OP_WR_VCR && !pwr_cycle_i
            |=> vcr_q == ($past(cmd_i.data[7:0]) & 8'hFB) ##1 vcr_o == $past(vcr_q);
    endproperty
    a_vcr_wr: assert property (p_vcr_wr) else $error("volatile write lost");
    property p_nv_wr;
        cmd_fire && cmd_i.op == sfv_pkg::SFV_OP_WR_NVCR && nvcr_q[`SFV_NV_LOCK] |=> nvcr_q == $past(cmd_i.data);
    endproperty
    a_nv_wr: assert property (p_nv_wr) else $error("nonvolatile write lost");
    property p_proto;
        pwr_cycle_i |=> quad_mode_o == !$past(nvcr_q[`SFV_NV_QUAD])
                        && dual_mode_o == ($past(nvcr_q[`SFV_NV_QUAD]) && !$past(nvcr_q[`SFV_NV_DUAL]));
    endproperty
    a_proto: assert property (p_proto) else $error("protocol select wrong");
    property p_load;
        pwr_cycle_i |=> vcr_q[`SFV_DUMMY_HI:`SFV_DUMMY_LO] == $past(nvcr_q[`SFV_NV_DUMMY_HI:`SFV_NV_DUMMY_LO]);
    endproperty
    a_load: assert property (p_load) else $error("power-on load wrong");
endmodule
`default_nettype wire

// ### sfv_volatile_config_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sfv_volatile_config_tb;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, pwr_cycle_i = 1'b0, cmd_valid_i = 1'b0, read_stop_i = 1'b0, stall = 1'b0;
    logic [3:0]         feature_opt_i = 4'h0;
    sfv_pkg::sfv_cmd_t  cmd_i = '0;
    logic               cmd_ready_o, out_valid_o, out_ready_i, xip_active_o, quad_mode_o, dual_mode_o;
    sfv_pkg::sfv_beat_t out_o;
    logic [7:0]         vcr_o;
    logic [3:0]         dummy_cnt_o;
    int                 miscompares = 0, n_checks = 0;

    always #2 clk_i = ~clk_i;

    sfv_volatile_config i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pwr_cycle_i(pwr_cycle_i),
        .feature_opt_i(feature_opt_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i),
        .read_stop_i(read_stop_i), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_o(out_o),
        .vcr_o(vcr_o), .dummy_cnt_o(dummy_cnt_o), .xip_active_o(xip_active_o), .quad_mode_o(quad_mode_o),
        .dual_mode_o(dual_mode_o));
    sfv_host_model i_host (.clk_i(clk_i), .stall_i(stall), .out_valid_i(out_valid_o), .beat_i(out_o),
        .ready_o(out_ready_i));

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("BAD %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic end_sim();
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic do_reset(input logic [3:0] feat);
        @(negedge clk_i);
        feature_opt_i = feat;
        sys_rst_i = 1'b1;
        repeat (8) @(negedge clk_i);
        sys_rst_i = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask

    // Offers one command and holds it until the accepting edge
    task automatic cmd(input sfv_pkg::sfv_op_t op, input logic [23:0] a, input logic [15:0] d);
        int i;
        @(negedge clk_i);
        cmd_i = '{op: op, addr: a, data: d};
        cmd_valid_i = 1'b1;
        for (i = 0; i < 200 && cmd_ready_o !== 1'b1; i++) @(negedge clk_i);
        @(posedge clk_i);
        @(negedge clk_i);
        cmd_valid_i = 1'b0;
    endtask

    task automatic wr_vcr(input logic [7:0] v);
        cmd(sfv_pkg::SFV_OP_WR_VCR, 24'h0, {8'h00, v});
        repeat (3) @(negedge clk_i);
    endtask

    task automatic rd_reg(input sfv_pkg::sfv_op_t op, input logic [15:0] e, input logic [15:0] m);
        int i;
        i_host.beats.delete();
        cmd(op, 24'h0, 16'h0000);
        for (i = 0; i < 20 && i_host.beats.size() == 0; i++) @(negedge clk_i);
        chk_bit("reg beat flag", 1'b1, i_host.beats[0].is_reg);
        chk("reg beat data", {8'h00, e & m}, {8'h00, i_host.beats[0].data & m});
    endtask

    task automatic t_reset();
        chk("vcr reset", 24'hFB, {16'h0, vcr_o});
        chk("dummy reset", 24'hA, {20'h0, dummy_cnt_o});
        chk_bit("xip reset", 1'b0, xip_active_o);
        chk_bit("quad reset", 1'b0, quad_mode_o);
        chk_bit("dual reset", 1'b0, dual_mode_o);
        chk_bit("ready after reset", 1'b1, cmd_ready_o);
    endtask

    task automatic t_regs();
        logic [3:0] codes[4] = '{4'h0, 4'h1, 4'hE, 4'hF};
        foreach (codes[i])
        begin
            wr_vcr({codes[i], 4'hB});
            chk("vcr value", {16'h0, codes[i], 4'hB}, {16'h0, vcr_o});
            chk("dummy decode", (codes[i] == 4'h0 || codes[i] == 4'hF) ? 24'hA : {20'h0, codes[i]},
                {20'h0, dummy_cnt_o});
            chk_bit("xip off", 1'b0, xip_active_o);
        end
        wr_vcr(8'h77);
        chk("reserved bit", 24'h73, {16'h0, vcr_o});
        chk_bit("xip on", 1'b1, xip_active_o);
        cmd(sfv_pkg::SFV_OP_NOP, 24'h0, 16'h00FF);
        repeat (3) @(negedge clk_i);
        chk("nop keeps vcr", 24'h73, {16'h0, vcr_o});
        rd_reg(sfv_pkg::SFV_OP_RD_VCR, 16'h0073, 16'h00FF);
    endtask

    // Fast read from near a 64-byte edge under every wrap code, with a stall
    task automatic t_read();
        logic [23:0] m, s;
        int          k, i;
        s = 24'h00003E;
        for (int w = 0; w < 4; w++)
        begin
            m = (w == 0) ? 24'hF : (w == 1) ? 24'h1F : (w == 2) ? 24'h3F : 24'hFFFFFF;
            wr_vcr({4'(w + 2), 2'b10, 2'(w)});
            i_host.beats.delete();
            cmd(sfv_pkg::SFV_OP_FAST_READ, s, 16'h0000);
            for (k = 0; k < 40 && out_valid_o !== 1'b1; k++) @(negedge clk_i);
            chk("dummy latency", 24'(w + 3), 24'(k));
            stall = 1'b1;
            repeat (5) @(negedge clk_i);
            stall = 1'b0;
            for (i = 0; i < 40 && i_host.beats.size() < 6; i++) @(negedge clk_i);
            read_stop_i = 1'b1;
            @(negedge clk_i);
            read_stop_i = 1'b0;
            for (i = 0; i < 6; i++)
            begin
                chk_bit("data flag", 1'b0, i_host.beats[i].is_reg);
                chk("burst addr", (s & ~m) | ((s + 24'(i)) & m), i_host.beats[i].addr);
            end
            repeat (8) @(negedge clk_i);
        end
    endtask

    task automatic t_nv();
        cmd(sfv_pkg::SFV_OP_WR_NVCR, 24'h0, 16'h3FF7);
        rd_reg(sfv_pkg::SFV_OP_RD_NVCR, 16'h3FF7, 16'hFFFF);
        pwr_cycle_i = 1'b1;
        @(negedge clk_i);
        pwr_cycle_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("vcr power-on", 24'h3B, {16'h0, vcr_o});
        chk("dummy power-on", 24'h3, {20'h0, dummy_cnt_o});
        chk_bit("quad on", 1'b1, quad_mode_o);
        chk_bit("dual off", 1'b0, dual_mode_o);
        cmd(sfv_pkg::SFV_OP_WR_NVCR, 24'h0, 16'hFFFA);
        pwr_cycle_i = 1'b1;
        @(negedge clk_i);
        pwr_cycle_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk_bit("quad off", 1'b0, quad_mode_o);
        chk_bit("dual on", 1'b1, dual_mode_o);
        cmd(sfv_pkg::SFV_OP_WR_NVCR, 24'h0, 16'hFFFF);
        rd_reg(sfv_pkg::SFV_OP_RD_NVCR, 16'hFFFA, 16'hFFFF);
    endtask

    task automatic t_feat();
        logic [3:0] f[3] = '{4'h2, 4'h4, 4'h5};
        foreach (f[i])
        begin
            do_reset(f[i]);
            wr_vcr(8'hFB);
            chk_bit("forced xip", f[i] != 4'h5, xip_active_o);
        end
    endtask

    initial
    begin
        #100000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        do_reset(4'h0);
        t_reset();
        t_regs();
        t_read();
        t_nv();
        t_feat();
        end_sim();
    end
endmodule
`default_nettype wire
